//--- verilog/parallel_io_port_with_strobe.sv
// Purpose: 16-line open-collector parallel port, strobe, two armable trips
// Assumes: Inputs synchronous to ref_clk except trip pins, which are synchronised
// Notes: Register access over Avalon-MM, one wait state per access
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Capture command latches the input lines
// - Armed trip pin low sets sticky flag
// - Trip one sets hw bit 13, summary bit 5
// - Trip two reports in hw bit 14
// - Disable then arm clears tripped flag
// - Disabled trip input ignores pin entirely
// - Two trip inputs fully independent
// - Direction mask bit one means input
// - Bit n maps to line n
// - Input lines pulled high, released by driver
// - Output value write leaves drivers unchanged
// - Send moves value to drivers, pulses strobe
// - Polarity setting selects strobe active level
// - Capture holds all sixteen line levels
// - Mask write drives lines immediately
// - Driver released when mask or value set
// - Zero pulls low; one releases line
// - Output updates sustain well above 200 kb/s
// - Capture and drive never same cycle
module parallel_io_port_with_strobe
    import pio_pkg::*;
#(
    parameter int STROBE_LEN = STROBE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire avm_req_t avm_req,
    output avm_rsp_t avm_rsp,
    // Parallel lines
    input wire logic [LINE_COUNT-1:0] line_in,
    output logic [LINE_COUNT-1:0] line_out,
    output logic [LINE_COUNT-1:0] line_oe_n,
    output logic strobe_out,
    // Trip inputs, active low
    input wire logic trip1_n,
    input wire logic trip2_n,
    // Service request summary
    output logic srq_out
);
    logic [LINE_COUNT-1:0] dir_q;
    logic [LINE_COUNT-1:0] outval_q;
    logic [LINE_COUNT-1:0] drv_q;
    logic [LINE_COUNT-1:0] capt_q;
    logic pol_q;
    logic [1:0] arm_q;
    logic [1:0] trip_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [7:0] stb_cnt_q;
    logic stb_act_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic acc;
    logic wr;
    logic send_cmd;
    logic capt_cmd;
    logic [31:0] hw_stat;
    logic [31:0] sum_stat;

    // Single wait state: request taken when ack_q is low, answered next cycle
    // Writes commit only on the answer edge, where the master completes
    assign acc = (avm_req.read | avm_req.write) & ~ack_q;
    assign wr = avm_req.write & ack_q;
    assign send_cmd = wr & (avm_req.address == OFS_CMD) & avm_req.writedata[CMD_SEND_BIT];
    assign capt_cmd = wr & (avm_req.address == OFS_CMD) & avm_req.writedata[CMD_CAPT_BIT];
    assign avm_rsp.waitrequest = (avm_req.read | avm_req.write) & ~ack_q;
    assign avm_rsp.readdata = rdata_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    // Direction mask, a one makes the line an input
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dir_q <= DIR_RST;
        end else if (wr && avm_req.address == OFS_DIR) begin
            dir_q <= avm_req.writedata[LINE_COUNT-1:0];
        end
    end

    // Output value is only staged here
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            outval_q <= OUTVAL_RST;
        end else if (wr && avm_req.address == OFS_OUTVAL) begin
            outval_q <= avm_req.writedata[LINE_COUNT-1:0];
        end
    end

    // Driver latch: a send commits the staged value; the mask is ORed in live
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            drv_q <= OUTVAL_RST;
        end else if (send_cmd) begin
            drv_q <= outval_q;
        end
    end

    // Open collector: drive low only where both mask and value are zero
    assign line_out = '0;
    assign line_oe_n = dir_q | drv_q;

    // Strobe polarity and trip arming
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pol_q <= 1'b1;
            arm_q <= 2'b00;
        end else if (wr && avm_req.address == OFS_CTRL) begin
            pol_q <= avm_req.writedata[CTRL_POL_BIT];
            arm_q[0] <= avm_req.writedata[CTRL_ARM1_BIT];
            arm_q[1] <= avm_req.writedata[CTRL_ARM2_BIT];
        end
    end

    // Strobe starts with the driver update, lasts a fixed count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stb_act_q <= 1'b0;
            stb_cnt_q <= 8'h00;
        end else if (send_cmd) begin
            stb_act_q <= 1'b1;
            stb_cnt_q <= 8'(STROBE_LEN - 1);
        end else if (stb_cnt_q != 8'h00) begin
            stb_cnt_q <= stb_cnt_q - 8'h01;
        end else begin
            stb_act_q <= 1'b0;
        end
    end

    assign strobe_out = pol_q ? stb_act_q : ~stb_act_q;

    // Capture is dropped when a send is in the same cycle, so the two never overlap
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            capt_q <= 16'h0000;
        end else if (capt_cmd && !send_cmd) begin
            capt_q <= line_in;
        end
    end

    // Trip pins are asynchronous, so two flops before any logic
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q <= 2'b11;
            sync2_q <= 2'b11;
        end else begin
            sync1_q <= {trip2_n, trip1_n};
            sync2_q <= sync1_q;
        end
    end

    // Sticky trips; clearing only by disarm, and a disarmed pin is ignored
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_trip
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    trip_q[gi] <= 1'b0;
                end else if (!arm_q[gi]) begin
                    trip_q[gi] <= 1'b0;
                end else if (!sync2_q[gi]) begin
                    trip_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always_comb begin
        hw_stat = 32'h0000_0000;
        hw_stat[HW_TRIP1_BIT] = trip_q[0];
        hw_stat[HW_TRIP2_BIT] = trip_q[1];
        sum_stat = 32'h0000_0000;
        sum_stat[SUM_TRIP_BIT] = |trip_q;
    end

    assign srq_out = |trip_q;

    // Read mux, registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc && avm_req.read) begin
            case (avm_req.address)
                OFS_DIR: rdata_q <= {16'h0000, dir_q};
                OFS_OUTVAL: rdata_q <= {16'h0000, outval_q};
                OFS_CTRL: rdata_q <= {29'h0000_0000, arm_q, pol_q};
                OFS_CAPT: rdata_q <= {16'h0000, capt_q};
                OFS_HWSTAT: rdata_q <= hw_stat;
                OFS_SUMSTAT: rdata_q <= sum_stat;
                default: rdata_q <= UNMAPPED_RD;
            endcase
        end
    end


    // Width check helper; a counter keeps the property short for the tools
    logic [7:0] stb_run_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stb_run_q <= 8'h00;
        end else if (send_cmd) begin
            stb_run_q <= 8'h01;
        end else if (stb_act_q) begin
            stb_run_q <= stb_run_q + 8'h01;
        end
    end

    // Register bus handshake
    a_wait_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc |-> avm_rsp.waitrequest)
        else $error("first request cycle not stalled");

    a_one_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc |=> ack_q && !avm_rsp.waitrequest)
        else $error("answer not one cycle after request");

    a_ack_drops: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ack_q |=> !ack_q)
        else $error("answer held longer than one cycle");

    // Line drivers
    a_mask_write_drives: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && avm_req.address == OFS_DIR) |=> (line_oe_n == (dir_q | drv_q))
            && dir_q == $past(avm_req.writedata[15:0]))
        else $error("mask write did not reach drivers");

    a_outval_staged: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr && avm_req.address == OFS_OUTVAL) |=> outval_q == $past(avm_req.writedata[15:0])
            && drv_q == $past(drv_q))
        else $error("value write touched drivers");

    a_value_staged_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !send_cmd |=> drv_q == $past(drv_q))
        else $error("drivers changed without send");

    a_send_commits: assert property (@(posedge ref_clk) disable iff (sys_rst)
        send_cmd |=> drv_q == $past(outval_q) && stb_act_q)
        else $error("send did not commit value and strobe");

    a_open_collector: assert property (@(posedge ref_clk) disable iff (sys_rst)
        line_out == 16'h0000 && ((dir_q | drv_q) == line_oe_n))
        else $error("driver not open collector");

    a_inputs_released: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dir_q == 16'hFFFF |-> line_oe_n == 16'hFFFF)
        else $error("input line pulled low");

    // Strobe
    a_strobe_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(stb_act_q) |-> $past(stb_run_q) == 8'(STROBE_LEN))
        else $error("strobe width wrong");

    a_strobe_polarity: assert property (@(posedge ref_clk) disable iff (sys_rst)
        strobe_out == (pol_q ~^ stb_act_q))
        else $error("strobe polarity wrong");

    a_strobe_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !stb_act_q |-> strobe_out == !pol_q)
        else $error("idle strobe level wrong");

    a_strobe_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        stb_cnt_q <= 8'(STROBE_LEN - 1))
        else $error("strobe counter out of range");

    // Capture
    a_capture_levels: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capt_cmd && !send_cmd |=> capt_q == $past(line_in))
        else $error("capture wrong");

    a_capture_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capt_cmd |=> capt_q == $past(capt_q))
        else $error("capture changed without command");

    a_half_duplex: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capt_cmd && send_cmd |=> capt_q == $past(capt_q))
        else $error("capture during send");

    // Trips
    a_sync_stages: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sync2_q == $past(sync1_q))
        else $error("synchroniser stage skipped");

    a_trip_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q[0] && !sync2_q[0] ##1 arm_q[0] |-> trip_q[0] && hw_stat[13] && sum_stat[5])
        else $error("trip one not reported");

    a_trip_two_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
        arm_q[1] && !sync2_q[1] ##1 arm_q[1] |-> trip_q[1] && hw_stat[14] && sum_stat[5])
        else $error("trip two not reported");

    a_trip_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        trip_q[0] && arm_q[0] |=> trip_q[0])
        else $error("trip one flag not sticky");

    a_trip_two_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        trip_q[1] && arm_q[1] |=> trip_q[1])
        else $error("trip two flag not sticky");

    a_no_spurious: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !trip_q[0] && sync2_q[0] |=> !trip_q[0])
        else $error("trip one set with pin high");

    a_disarm_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(arm_q[0]) |-> !trip_q[0])
        else $error("disarmed trip flag set");

    a_disarm_two: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(arm_q[1]) |-> !trip_q[1])
        else $error("disarmed trip two flag set");

    a_trip_two_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hw_stat[14] == trip_q[1] && hw_stat[13] == trip_q[0])
        else $error("trip two bit wrong");

    a_summary: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sum_stat[5] == (trip_q[0] | trip_q[1]) && srq_out == (trip_q[0] | trip_q[1]))
        else $error("summary bit wrong");

    // Read path
    a_read_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc && avm_req.read && avm_req.address == OFS_DIR
            |=> avm_rsp.readdata == {16'h0000, $past(dir_q)})
        else $error("mask read wrong");

    a_read_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc && avm_req.read && avm_req.address == OFS_CAPT
            |=> avm_rsp.readdata == {16'h0000, $past(capt_q)})
        else $error("capture read wrong");

    a_read_ctrl: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc && avm_req.read && avm_req.address == OFS_CTRL
            |=> avm_rsp.readdata == {29'h0000_0000, $past(arm_q), $past(pol_q)})
        else $error("control read wrong");

    a_read_hwstat: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc && avm_req.read && avm_req.address == OFS_HWSTAT
            |=> avm_rsp.readdata == $past(hw_stat))
        else $error("status read wrong");

    a_read_cmd_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        acc && avm_req.read && avm_req.address == OFS_CMD
            |=> avm_rsp.readdata == UNMAPPED_RD)
        else $error("command read not zero");

    // Reset
    a_reset_state: assert property (@(posedge ref_clk)
        sys_rst |=> arm_q == 2'b00 && trip_q == 2'b00 && dir_q == DIR_RST
            && drv_q == OUTVAL_RST && !stb_act_q)
        else $error("reset state wrong");
endmodule : parallel_io_port_with_strobe
`default_nettype wire

//--- shared/pio_pkg.sv
// Purpose: Shared constants and types for the parallel port with strobe
// Assumes: 32-bit Avalon-MM register slave, word addressed by byte offset
// Notes: Offsets are byte addresses of aligned words
package pio_pkg;
    localparam int LINE_COUNT = 16;
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_OUTVAL = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_CAPT = 8'h10;
    localparam logic [7:0] OFS_HWSTAT = 8'h14;
    localparam logic [7:0] OFS_SUMSTAT = 8'h18;
    localparam int CMD_SEND_BIT = 0;
    localparam int CMD_CAPT_BIT = 1;
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_ARM1_BIT = 1;
    localparam int CTRL_ARM2_BIT = 2;
    localparam int HW_TRIP1_BIT = 13;
    localparam int HW_TRIP2_BIT = 14;
    localparam int SUM_TRIP_BIT = 5;
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] OUTVAL_RST = 16'h0000;
    localparam int STROBE_NS = 1000;
    localparam int CLK_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avm_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avm_rsp_t;
    typedef struct packed {
        logic [15:0] line_in;
        logic [15:0] line_out;
        logic [15:0] line_oe_n;
    } lines_t;
endpackage : pio_pkg

//--- dv/radio_model.sv
// Purpose: Far-side device model for the parallel port
// Assumes: Lines resolve wired-AND against pull-ups
// Notes: Latches on strobe level, not edge, so data has settled
`timescale 1ns/1ps
`default_nettype none
module radio_model (
    // Clock
    input wire logic ref_clk,
    // Wire side
    input wire logic [15:0] dut_oe_n,
    input wire logic [15:0] pull_low,
    input wire logic strobe_out,
    input wire logic strobe_pol,
    output logic [15:0] line_in,
    output logic [15:0] latched_q
);
    // Pulled high unless some party sinks the line
    assign line_in = dut_oe_n & ~pull_low;
    always_ff @(posedge ref_clk) begin
        if (strobe_out == strobe_pol) begin
            latched_q <= line_in;
        end
    end
endmodule : radio_model
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Register-level tests of the parallel port with strobe
// Assumes: One wait state per access, but the bus task waits for it
// Notes: Strobe width set through the parameter, equal to the default 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pio_pkg::*;
    localparam int SLEN = 20;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    avm_req_t req = '0;
    avm_rsp_t rsp;
    logic [15:0] line_in, line_out, oe_n, latched;
    logic [15:0] pull_low = 16'h0000;
    logic strobe_out, srq;
    logic trip1_n = 1'b1;
    logic trip2_n = 1'b1;
    logic pol = 1'b1;
    logic [31:0] q;
    int n_mismatch = 0;
    int comparisons = 0;
    int run = 0;
    int last_run = 0;
    parallel_io_port_with_strobe #(.STROBE_LEN(SLEN)) u_parallel_io_port_with_strobe (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avm_req(req), .avm_rsp(rsp),
        .line_in(line_in), .line_out(line_out), .line_oe_n(oe_n), .strobe_out(strobe_out),
        .trip1_n(trip1_n), .trip2_n(trip2_n), .srq_out(srq));
    radio_model u_radio_model (.ref_clk(ref_clk), .dut_oe_n(oe_n), .pull_low(pull_low),
        .strobe_out(strobe_out), .strobe_pol(pol), .line_in(line_in), .latched_q(latched));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // Length of the last active strobe run, in cycles
    always @(negedge ref_clk) begin
        if (strobe_out === pol) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Waits an edge first so a release and a new request never share a time step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        req.address <= a;
        req.write <= wr;
        req.read <= !wr;
        req.writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk({oe_n, line_out}, 32'h00000000);
        chk({strobe_out, srq}, 32'h0);
        rd_chk(OFS_DIR, 32'h0);
        rd_chk(8'h1C, UNMAPPED_RD);
        bus(1'b1, OFS_DIR, 32'h0);
        @(negedge ref_clk);
        chk(oe_n, 32'h0);
        bus(1'b1, OFS_DIR, 32'h00FF);
        @(negedge ref_clk);
        chk(oe_n, 32'h00FF);
        bus(1'b1, OFS_OUTVAL, 32'hA500);
        @(negedge ref_clk);
        chk(oe_n, 32'h00FF);
        bus(1'b1, OFS_CMD, 32'h1);
        @(negedge ref_clk);
        chk(oe_n, 32'hA5FF);
        repeat (SLEN + 4) @(posedge ref_clk);
        chk(last_run, SLEN);
        chk(latched, 32'hA5FF);
        bus(1'b1, OFS_CTRL, 32'h0);
        pol <= 1'b0;
        bus(1'b1, OFS_OUTVAL, 32'h5A00);
        bus(1'b1, OFS_CMD, 32'h1);
        repeat (SLEN + 4) @(posedge ref_clk);
        chk({last_run[7:0], strobe_out}, {8'(SLEN), 1'b1});
        chk(latched, 32'h5AFF);
        // Input changes only between captures, never during one
        pull_low <= 16'h0012;
        bus(1'b1, OFS_CMD, 32'h2);
        rd_chk(OFS_CAPT, 32'h5AED);
        @(posedge ref_clk);
        pull_low <= 16'h0000;
        bus(1'b1, OFS_CMD, 32'h3);
        rd_chk(OFS_CAPT, 32'h5AED);
        trip1_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd_chk(OFS_HWSTAT, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h2);
        repeat (6) @(posedge ref_clk);
        trip1_n <= 1'b1;
        rd_chk(OFS_HWSTAT, 32'h2000);
        rd_chk(OFS_SUMSTAT, 32'h20);
        chk(srq, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h6);
        trip2_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        trip2_n <= 1'b1;
        rd_chk(OFS_HWSTAT, 32'h6000);
        bus(1'b1, OFS_CTRL, 32'h4);
        bus(1'b1, OFS_CTRL, 32'h6);
        rd_chk(OFS_HWSTAT, 32'h4000);
        bus(1'b1, OFS_CTRL, 32'h0);
        rd_chk(OFS_SUMSTAT, 32'h0);
        chk(srq, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
